// ==== src/wtl_wake_timer.sv ====
// wake timer with reload, underflow actions and card sense sequencing
module wtl_wake_timer
#(
    parameter int COUNT_W = 16
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic read_during_rx,
    input wire logic low_freq_oscillator,
    input wire logic [15:0] field_window_count,
    input wire logic rx_active,
    input wire logic flag_clear,
    output logic wake_underflow_flag,
    output logic wake_active_flag,
    output logic [COUNT_W-1:0] wake_count,
    output logic osc_trim_start,
    output logic wake_request,
    output logic card_sense_start,
    output logic rf_field_en,
    input wire logic field_window_done,
    input wire logic card_present,
    input wire logic card_irq_en,
    output logic card_irq_req,
    output logic stay_active,
    output logic power_down_req
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (COUNT_W != 16)
    begin : g_width_check
        $error("wake timer count width must be 16");
    end

    // ************************************************************
    // state
    // ************************************************************
    wtl_pkg::wtl_ctrl_type ctrl_r;
    wtl_pkg::wtl_ctrl_type ctrl_nxt;
    wtl_pkg::wtl_sense_type sense_r;
    wtl_pkg::wtl_sense_type sense_nxt;
    logic running_r;
    logic running_nxt;
    logic [COUNT_W-1:0] count_r;
    logic [COUNT_W-1:0] count_nxt;
    logic [7:0] reload_high_r;
    logic [7:0] reload_high_nxt;
    logic [7:0] reload_low_r;
    logic [7:0] reload_low_nxt;
    logic flag_r;
    logic flag_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rx_read_r;
    logic rx_read_nxt;
    logic trim_r;
    logic trim_nxt;
    logic wake_r;
    logic wake_nxt;
    logic sense_start_r;
    logic sense_start_nxt;
    logic irq_r;
    logic irq_nxt;
    logic stay_r;
    logic stay_nxt;
    logic pdown_r;
    logic pdown_nxt;
    logic tick;
    logic underflow;
    logic start_event;
    logic ctrl_write;
    logic [COUNT_W-1:0] reload_word;

    // ************************************************************
    // prescaler
    // ************************************************************
    wtl_prescaler wtl_prescaler_inst
    (
        .core_clk(core_clk),
        .rst(rst),
        .low_freq_oscillator(low_freq_oscillator),
        .wake_clock_select(ctrl_r.wake_clock_select),
        .restart(start_event),
        .tick(tick)
    );

    // ************************************************************
    // decode helpers
    // ************************************************************
    assign reload_word = {reload_high_r, reload_low_r};
    assign ctrl_write = reg_wr && (reg_addr == wtl_pkg::ADDR_WAKE_CONTROL);
    // start only when qualified and asking to run
    assign start_event = ctrl_write && reg_wdata[wtl_pkg::BIT_QUALIFIER]
        && reg_wdata[wtl_pkg::BIT_ACTIVE];
    // tick arriving while running with the count already at zero
    assign underflow = running_r && tick && (count_r == '0);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        running_nxt = running_r;
        count_nxt = count_r;
        reload_high_nxt = reload_high_r;
        reload_low_nxt = reload_low_r;
        flag_nxt = flag_r;
        sense_nxt = sense_r;
        rdata_nxt = rdata_r;
        rx_read_nxt = 1'b0;
        trim_nxt = 1'b0;
        wake_nxt = 1'b0;
        sense_start_nxt = 1'b0;
        irq_nxt = 1'b0;
        stay_nxt = stay_r;
        pdown_nxt = 1'b0;

        // counting
        if (running_r && tick)
        begin
            if (count_r == '0)
            begin
                if (ctrl_r.wake_auto_reload_en || ctrl_r.underflow_card_sense_en)
                    count_nxt = reload_word;
                else
                    running_nxt = 1'b0;
            end
            else
                count_nxt = count_r - 16'h0001;
        end

        // underflow actions
        if (flag_clear)
            flag_nxt = 1'b0;
        if (underflow)
        begin
            flag_nxt = 1'b1;
            trim_nxt = ctrl_r.underflow_osc_trim_en;
            wake_nxt = ctrl_r.underflow_wake_en;
        end

        // card sense sequence
        case (sense_r)
            wtl_pkg::SENSE_IDLE:
            begin
                if (underflow && ctrl_r.underflow_card_sense_en)
                begin
                    sense_start_nxt = 1'b1;
                    stay_nxt = 1'b0;
                    sense_nxt = wtl_pkg::SENSE_FIELD;
                end
            end
            wtl_pkg::SENSE_FIELD:
            begin
                if (field_window_done)
                begin
                    sense_nxt = wtl_pkg::SENSE_IDLE;
                    if (card_present)
                    begin
                        irq_nxt = card_irq_en;
                        stay_nxt = card_irq_en;
                    end
                    else
                        pdown_nxt = ctrl_r.underflow_wake_en;
                end
            end
            default:
                sense_nxt = wtl_pkg::SENSE_IDLE;
        endcase

        // register writes
        if (ctrl_write)
        begin
            ctrl_nxt = reg_wdata[5:0];
            if (reg_wdata[wtl_pkg::BIT_QUALIFIER])
                running_nxt = reg_wdata[wtl_pkg::BIT_ACTIVE];
            if (start_event)
                count_nxt = reload_word;
        end
        else if (reg_wr && (reg_addr == wtl_pkg::ADDR_RELOAD_HIGH))
            reload_high_nxt = reg_wdata;
        else if (reg_wr && (reg_addr == wtl_pkg::ADDR_RELOAD_LOW))
            reload_low_nxt = reg_wdata;

        // register reads
        if (reg_rd)
        begin
            if (reg_addr == wtl_pkg::ADDR_FIELD_COUNT_HIGH)
            begin
                rdata_nxt = field_window_count[15:8];
                rx_read_nxt = rx_active;
            end
            else if (reg_addr == wtl_pkg::ADDR_FIELD_COUNT_LOW)
            begin
                rdata_nxt = field_window_count[7:0];
                rx_read_nxt = rx_active;
            end
            else if (reg_addr == wtl_pkg::ADDR_WAKE_CONTROL)
                rdata_nxt = {running_r, 1'b0, ctrl_r};
            else if (reg_addr == wtl_pkg::ADDR_RELOAD_HIGH)
                rdata_nxt = reload_high_r;
            else if (reg_addr == wtl_pkg::ADDR_RELOAD_LOW)
                rdata_nxt = reload_low_r;
            else
                rdata_nxt = 8'h00;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_r <= wtl_pkg::RESET_CTRL;
            running_r <= 1'b0;
            count_r <= '0;
            reload_high_r <= wtl_pkg::RESET_RELOAD_BYTE;
            reload_low_r <= wtl_pkg::RESET_RELOAD_BYTE;
            flag_r <= 1'b0;
            sense_r <= wtl_pkg::SENSE_IDLE;
            rdata_r <= 8'h00;
            rx_read_r <= 1'b0;
            trim_r <= 1'b0;
            wake_r <= 1'b0;
            sense_start_r <= 1'b0;
            irq_r <= 1'b0;
            stay_r <= 1'b0;
            pdown_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            running_r <= running_nxt;
            count_r <= count_nxt;
            reload_high_r <= reload_high_nxt;
            reload_low_r <= reload_low_nxt;
            flag_r <= flag_nxt;
            sense_r <= sense_nxt;
            rdata_r <= rdata_nxt;
            rx_read_r <= rx_read_nxt;
            trim_r <= trim_nxt;
            wake_r <= wake_nxt;
            sense_start_r <= sense_start_nxt;
            irq_r <= irq_nxt;
            stay_r <= stay_nxt;
            pdown_r <= pdown_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata = rdata_r;
    assign read_during_rx = rx_read_r;
    assign wake_underflow_flag = flag_r;
    assign wake_active_flag = running_r;
    assign wake_count = count_r;
    assign osc_trim_start = trim_r;
    assign wake_request = wake_r;
    assign card_sense_start = sense_start_r;
    // field stays on while the field window runs
    assign rf_field_en = (sense_r == wtl_pkg::SENSE_FIELD);
    assign card_irq_req = irq_r;
    assign stay_active = stay_r;
    assign power_down_req = pdown_r;

endmodule : wtl_wake_timer

// ==== pkg/wtl_pkg.sv ====
// wake timer package: register map, field layout, reset values and types
package wtl_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_FIELD_COUNT_HIGH = 8'h21;
    localparam logic [7:0] ADDR_FIELD_COUNT_LOW = 8'h22;
    localparam logic [7:0] ADDR_WAKE_CONTROL = 8'h23;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h24;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'h25;

    // ************************************************************
    // control register field positions
    // ************************************************************
    localparam int BIT_ACTIVE = 7;
    localparam int BIT_QUALIFIER = 6;
    localparam int BIT_TRIM = 5;
    localparam int BIT_SENSE = 4;
    localparam int BIT_RELOAD = 3;
    localparam int BIT_WAKE = 2;
    localparam int BIT_CLK_HI = 1;
    localparam int BIT_CLK_LO = 0;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RESET_RELOAD_BYTE = 8'h00;
    localparam logic [5:0] RESET_CTRL = 6'h00;

    // ************************************************************
    // clock select codes and divide ratios
    // ************************************************************
    localparam logic [1:0] CLK_SEL_DIV1 = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV8 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV16 = 2'h2;
    localparam logic [1:0] CLK_SEL_DIV32 = 2'h3;
    localparam logic [5:0] DIV_RATIO_1 = 6'h01;
    localparam logic [5:0] DIV_RATIO_8 = 6'h08;
    localparam logic [5:0] DIV_RATIO_16 = 6'h10;
    localparam logic [5:0] DIV_RATIO_32 = 6'h20;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic underflow_osc_trim_en;
        logic underflow_card_sense_en;
        logic wake_auto_reload_en;
        logic underflow_wake_en;
        logic [1:0] wake_clock_select;
    } wtl_ctrl_type;

    typedef enum logic [1:0] {
        SENSE_IDLE = 2'b01,
        SENSE_FIELD = 2'b10
    } wtl_sense_type;

endpackage : wtl_pkg

// ==== src/wtl_prescaler.sv ====
// low frequency oscillator edge detector and selectable prescaler
module wtl_prescaler
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic low_freq_oscillator,
    input wire logic [1:0] wake_clock_select,
    input wire logic restart,
    output logic tick
);

    logic osc_prev_r;
    logic osc_prev_nxt;
    logic [5:0] div_cnt_r;
    logic [5:0] div_cnt_nxt;
    logic tick_r;
    logic tick_nxt;
    logic [5:0] ratio;
    logic rise;

    // ************************************************************
    // ratio decode and divider
    // ************************************************************
    always_comb
    begin
        if (wake_clock_select == wtl_pkg::CLK_SEL_DIV8)
            ratio = wtl_pkg::DIV_RATIO_8;
        else if (wake_clock_select == wtl_pkg::CLK_SEL_DIV16)
            ratio = wtl_pkg::DIV_RATIO_16;
        else if (wake_clock_select == wtl_pkg::CLK_SEL_DIV32)
            ratio = wtl_pkg::DIV_RATIO_32;
        else
            ratio = wtl_pkg::DIV_RATIO_1;
        rise = low_freq_oscillator & ~osc_prev_r;
        osc_prev_nxt = low_freq_oscillator;
        div_cnt_nxt = div_cnt_r;
        tick_nxt = 1'b0;
        if (restart)
            div_cnt_nxt = 6'h00;
        else if (rise)
        begin
            if (div_cnt_r + 6'h01 >= ratio)
            begin
                div_cnt_nxt = 6'h00;
                tick_nxt = 1'b1;
            end
            else
                div_cnt_nxt = div_cnt_r + 6'h01;
        end
    end

    // registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            osc_prev_r <= 1'b0;
            div_cnt_r <= 6'h00;
            tick_r <= 1'b0;
        end
        else
        begin
            osc_prev_r <= osc_prev_nxt;
            div_cnt_r <= div_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : wtl_prescaler

// ==== bench/wtl_wake_timer_chk.sv ====
// port checker for the wake timer
module wtl_chk
#(
    parameter int COUNT_W = 16
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic read_during_rx,
    input wire logic [15:0] field_window_count,
    input wire logic rx_active,
    input wire logic wake_underflow_flag,
    input wire logic wake_active_flag,
    input wire logic [COUNT_W-1:0] wake_count,
    input wire logic osc_trim_start,
    input wire logic wake_request,
    input wire logic card_sense_start,
    input wire logic rf_field_en,
    input wire logic field_window_done,
    input wire logic card_present,
    input wire logic card_irq_en,
    input wire logic card_irq_req,
    input wire logic stay_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // ************************************************************
    // properties
    // ************************************************************
    // underflow seen one cycle back: running with zero count
    sequence s_uf;
        $past(wake_active_flag) && ($past(wake_count) == '0) && wake_underflow_flag;
    endsequence
    property p_trim; osc_trim_start |-> s_uf; endproperty
    property p_wake; wake_request |-> s_uf; endproperty
    property p_sense; card_sense_start |-> s_uf ##1 rf_field_en; endproperty
    property p_gap; card_sense_start |-> wake_active_flag; endproperty
    property p_irq;
        card_irq_req |-> $past(field_window_done && card_present && card_irq_en) && stay_active;
    endproperty
    property p_start;
        $rose(wake_active_flag) |-> $past(reg_wr && reg_addr == wtl_pkg::ADDR_WAKE_CONTROL
            && reg_wdata[wtl_pkg::BIT_QUALIFIER] && reg_wdata[wtl_pkg::BIT_ACTIVE]);
    endproperty
    property p_halt;
        $fell(wake_active_flag) && !$past(reg_wr) |-> wake_count == '0 && wake_underflow_flag;
    endproperty
    property p_low;
        reg_rd && reg_addr == wtl_pkg::ADDR_FIELD_COUNT_LOW
            |=> reg_rdata == $past(field_window_count[7:0]);
    endproperty
    property p_rx;
        reg_rd && rx_active && reg_addr == wtl_pkg::ADDR_FIELD_COUNT_HIGH |=> read_during_rx;
    endproperty
    property p_run;
        reg_rd && reg_addr == wtl_pkg::ADDR_WAKE_CONTROL
            |=> reg_rdata[7] == $past(wake_active_flag) && !reg_rdata[6];
    endproperty
    property p_dec;
        wake_active_flag && $past(wake_active_flag) && !$past(reg_wr)
            && wake_count != $past(wake_count)
            |-> wake_count == $past(wake_count) - 1 || $past(wake_count) == '0;
    endproperty
    a_trim: assert property (p_trim) else $error("trim start without underflow");
    a_wake: assert property (p_wake) else $error("wake request without underflow");
    a_sense: assert property (p_sense) else $error("card sense launch wrong");
    a_gap: assert property (p_gap) else $error("timer not running at launch");
    a_irq: assert property (p_irq) else $error("card irq without cause");
    a_start: assert property (p_start) else $error("run set without qualifier");
    a_halt: assert property (p_halt) else $error("timer stopped early");
    a_low: assert property (p_low) else $error("field count low wrong");
    a_rx: assert property (p_rx) else $error("read in reception not flagged");
    a_run: assert property (p_run) else $error("control read wrong");
    a_dec: assert property (p_dec) else $error("count step wrong");
endmodule : wtl_chk

bind wtl_wake_timer wtl_chk #(.COUNT_W(COUNT_W)) wtl_chk_inst (.core_clk, .rst, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .read_during_rx, .field_window_count, .rx_active,
    .wake_underflow_flag, .wake_active_flag, .wake_count, .osc_trim_start, .wake_request,
    .card_sense_start, .rf_field_en, .field_window_done, .card_present, .card_irq_en,
    .card_irq_req, .stay_active);

// ==== bench/wtl_wake_timer_tb.sv ====
// self-checking bench for the wake timer
module wtl_wake_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic low_freq_oscillator = 1'b0;
    logic [15:0] field_window_count = 16'h0000;
    logic rx_active = 1'b0;
    logic flag_clear = 1'b0;
    logic field_window_done = 1'b0;
    logic card_present = 1'b0;
    logic card_irq_en = 1'b0;
    logic [7:0] reg_rdata;
    logic [15:0] wake_count;
    logic read_during_rx, wake_underflow_flag, wake_active_flag, osc_trim_start;
    logic wake_request, card_sense_start, rf_field_en, card_irq_req, stay_active, power_down_req;
    int mismatches = 0;
    int n_compared = 0;
    int n_trim = 0;
    int n_wake = 0;
    int n_sense = 0;
    int n_irq = 0;
    int n_pd = 0;
    int ratio[4] = '{1, 8, 16, 32};

    wtl_wake_timer #(.COUNT_W(16)) wtl_wake_timer_inst (.core_clk, .rst, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .read_during_rx, .low_freq_oscillator,
        .field_window_count, .rx_active, .flag_clear, .wake_underflow_flag, .wake_active_flag,
        .wake_count, .osc_trim_start, .wake_request, .card_sense_start, .rf_field_en,
        .field_window_done, .card_present, .card_irq_en, .card_irq_req, .stay_active,
        .power_down_req);

    // clock
    always #10 core_clk = ~core_clk;

    // count one-cycle output pulses
    always @(posedge core_clk)
    begin
        n_trim <= n_trim + int'(osc_trim_start === 1'b1);
        n_wake <= n_wake + int'(wake_request === 1'b1);
        n_sense <= n_sense + int'(card_sense_start === 1'b1);
        n_irq <= n_irq + int'(card_irq_req === 1'b1);
        n_pd <= n_pd + int'(power_down_req === 1'b1);
    end

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        check(what, reg_rdata, exp);
    endtask : rd

    // oscillator rises, each followed by settle time
    task automatic osc_rise(int n);
        repeat (n)
        begin
            @(negedge core_clk);
            low_freq_oscillator = 1'b1;
            repeat (3) @(negedge core_clk);
            low_freq_oscillator = 1'b0;
            repeat (5) @(negedge core_clk);
        end
    endtask : osc_rise

    task automatic window_end();
        @(negedge core_clk);
        field_window_done = 1'b1;
        @(negedge core_clk);
        field_window_done = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : window_end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // hang guard
    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        results();
    end

    // main sequence
    initial
    begin
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        rd(wtl_pkg::ADDR_RELOAD_HIGH, 8'h00, "reload_high");
        rd(wtl_pkg::ADDR_WAKE_CONTROL, 8'h00, "control");
        rd(8'h30, 8'h00, "unmapped");
        field_window_count = 16'hA55A;
        rx_active = 1'b1;
        rd(wtl_pkg::ADDR_FIELD_COUNT_HIGH, 8'hA5, "field_high");
        check("rx read flag", read_during_rx, 1'b1);
        rx_active = 1'b0;
        rd(wtl_pkg::ADDR_FIELD_COUNT_LOW, 8'h5A, "field_low");
        check("no rx read flag", read_during_rx, 1'b0);
        $display("test register map done");
        wr(wtl_pkg::ADDR_WAKE_CONTROL, 8'h8C);
        check("no qualifier", wake_active_flag, 1'b0);
        rd(wtl_pkg::ADDR_WAKE_CONTROL, 8'h0C, "control cfg");
        wr(wtl_pkg::ADDR_RELOAD_LOW, 8'h03);
        rd(wtl_pkg::ADDR_RELOAD_LOW, 8'h03, "reload_low");
        wr(wtl_pkg::ADDR_WAKE_CONTROL, 8'hC4);
        check("started", wake_active_flag, 1'b1);
        check("loaded", wake_count, 16'h0003);
        wr(wtl_pkg::ADDR_RELOAD_LOW, 8'h09);
        check("reload held off", wake_count, 16'h0003);
        osc_rise(3);
        check("counted down", wake_count, 16'h0000);
        rd(wtl_pkg::ADDR_WAKE_CONTROL, 8'h84, "running");
        osc_rise(1);
        check("halted", wake_active_flag, 1'b0);
        check("flag", wake_underflow_flag, 1'b1);
        check("wake pulses", n_wake, 1);
        check("trim pulses", n_trim, 0);
        @(negedge core_clk);
        flag_clear = 1'b1;
        @(negedge core_clk);
        flag_clear = 1'b0;
        check("flag cleared", wake_underflow_flag, 1'b0);
        $display("test one shot done");
        for (int s = 0; s < 4; s++)
        begin
            wr(wtl_pkg::ADDR_RELOAD_LOW, 8'h01);
            wr(wtl_pkg::ADDR_WAKE_CONTROL, 8'hC0 | 8'(s));
            osc_rise(ratio[s] - 1);
            check("before tick", wake_count, 16'h0001);
            osc_rise(1);
            check("after tick", wake_count, 16'h0000);
        end
        wr(wtl_pkg::ADDR_WAKE_CONTROL, 8'h40);
        check("stopped", wake_active_flag, 1'b0);
        $display("test clock select done");
        card_present = 1'b1;
        card_irq_en = 1'b1;
        wr(wtl_pkg::ADDR_RELOAD_LOW, 8'h02);
        // trim timer set up outside, never the field timer while card sense runs
        wr(wtl_pkg::ADDR_WAKE_CONTROL, 8'hF8);
        osc_rise(3);
        check("trim", n_trim, 1);
        check("launch", n_sense, 1);
        check("reloaded", wake_count, 16'h0002);
        check("no gap", wake_active_flag, 1'b1);
        check("field on", rf_field_en, 1'b1);
        window_end();
        check("card irq", n_irq, 1);
        check("stay active", stay_active, 1'b1);
        check("field off", rf_field_en, 1'b0);
        $display("test card found done");
        card_present = 1'b0;
        // wake enable set so a run without card ends in power down
        wr(wtl_pkg::ADDR_WAKE_CONTROL, 8'hDC);
        osc_rise(3);
        check("launch again", n_sense, 2);
        check("wake again", n_wake, 2);
        check("stay cleared", stay_active, 1'b0);
        window_end();
        check("power down", n_pd, 1);
        check("no irq", n_irq, 1);
        $display("test no card done");
        results();
    end
endmodule : wtl_wake_timer_tb
